// >>> hw/asmr_defs.svh
`ifndef ASMR_DEFS_SVH
`define ASMR_DEFS_SVH

// Register addresses carried in the command byte
`define ASMR_ADDR_STATUS   6'h00
`define ASMR_ADDR_CONTROL  6'h01
`define ASMR_ADDR_IFACE    6'h02
`define ASMR_ADDR_DATA     6'h04

// Reset values
`define ASMR_STATUS_RST    8'h80
`define ASMR_CONTROL_RST   16'h0000
`define ASMR_IFACE_RST     16'h0000
`define ASMR_DATA_RST      24'h000000

// Status fields
`define ASMR_ST_RDY        7
`define ASMR_ST_ERR        6
`define ASMR_ST_CRC        5

// Control fields
`define ASMR_CT_REFEN      15
`define ASMR_CT_DELAY_LSB  8
`define ASMR_CT_MODE_LSB   4
`define ASMR_CT_CLK_LSB    2
`define ASMR_CT_MASK       16'h877c

// Interface fields
`define ASMR_IF_APPEND     6
`define ASMR_IF_CRCEN      2
`define ASMR_IF_MASK       16'h0044

// Conversion modes
`define ASMR_MODE_CONT     3'h0
`define ASMR_MODE_SINGLE   3'h1
`define ASMR_MODE_STANDBY  3'h2

// Clamp values
`define ASMR_FULL_SCALE    24'hffffff
`define ASMR_ZERO_SCALE    24'h000000

// Serial frame lengths in bits, last bit counts and the checksum polynomial
`define ASMR_LEN_BYTE      6'h08
`define ASMR_LEN_HALF      6'h10
`define ASMR_LEN_WORD      6'h18
`define ASMR_LEN_APPEND    6'h20
`define ASMR_CMD_LAST      6'h07
`define ASMR_CRC_LAST      6'h07
`define ASMR_CRC_POLY      8'h07

`endif

// >>> hw/asmr_pkg.sv
package asmr_pkg;

	typedef enum logic [1:0] {
		ASMR_LK_CMD  = 2'h0,
		ASMR_LK_DATA = 2'h1,
		ASMR_LK_CHK  = 2'h3,
		ASMR_LK_FIN  = 2'h2
	} asmr_link_st_t;

	typedef struct packed {
		logic        valid;
		logic [23:0] value;
		logic [1:0]  channel;
		logic        over;
		logic        under;
	} asmr_result_t;

	typedef struct packed {
		logic       ref_en;
		logic [2:0] delay;
		logic [2:0] mode;
		logic [1:0] clk_sel;
	} asmr_ctrl_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [15:0] control;
		logic [15:0] iface;
		logic [23:0] data;
	} asmr_shadow_t;

endpackage : asmr_pkg

// >>> hw/asmr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module asmr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Foreign level in, settled level out
	input  wire logic d,
	output logic      q
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic q_reg;

	// Output follows only when the two later stages agree
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			q_reg  <= RST_VAL;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= (s2_reg == s3_reg) ? s3_reg : q_reg;
		end
	end

	assign q = q_reg;

endmodule : asmr_sync

`default_nettype wire

// >>> hw/asmr_crc8.sv
`timescale 1ns/1ps
`default_nettype none
`include "asmr_defs.svh"

module asmr_crc8 (
	// Serial checksum step
	input  wire logic [7:0] crc,
	input  wire logic       bit_in,
	output logic [7:0]      crc_next
);

	wire fb = crc[7] ^ bit_in;

	assign crc_next = {crc[6:0], 1'b0} ^ (fb ? `ASMR_CRC_POLY : 8'h00);

endmodule : asmr_crc8

`default_nettype wire

// >>> hw/asmr_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "asmr_defs.svh"

// Contract
// - The status register is eight bits wide and read only, so writes leave it unchanged.
// - With the append bit of the interface register set, every data read is followed by the status byte.
// - While chip select is low and no read is shifting out, the serial output shows the data-ready flag.
// - The data-ready flag goes low when a new result, or a calibration result, has been written.
// - The data-ready flag resets to 1, meaning waiting, and a data register read returns it to 1.
// - Overrange sets the range-error flag with result all ones, underrange sets it with result all zeros.
// - The range-error flag is set only on a result write and clears on the first clean result, a control register write or sync low.
// - A register write with a bad checksum sets the checksum-error flag, and a status read clears it.
// - The channel field holds the channel of the result now in the data register, 00 high voltage.
// - A control register write resets the filter, returns data-ready to 1 and starts a conversion.
// - Control bit 15 enables the reference and its output, and bits 14 to 11 stay zero.
// - Mode 000 is continuous, 001 one result then standby, 010 standby.
module asmr_core (
	// System clock and reset
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	// Serial link
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   din,
	output logic                        dout,
	output logic                        dout_oe,
	// Sync pin
	input  wire logic                   sync_n,
	// Converter core
	input  wire asmr_pkg::asmr_result_t result,
	input  wire logic                   cal_done,
	output asmr_pkg::asmr_ctrl_t        ctrl,
	output logic                        filter_reset,
	output logic                        conv_start,
	output logic                        reference_output_pin
);

	// Frame length of a register, in bits
	function automatic logic [5:0] asmr_len(input logic [5:0] addr, input logic append);
		logic [5:0] len;
		len = `ASMR_LEN_BYTE;
		if (addr == `ASMR_ADDR_CONTROL || addr == `ASMR_ADDR_IFACE) begin
			len = `ASMR_LEN_HALF;
		end else if (addr == `ASMR_ADDR_DATA) begin
			len = append ? `ASMR_LEN_APPEND : `ASMR_LEN_WORD;
		end
		return len;
	endfunction : asmr_len

	// Read value, left aligned
	function automatic logic [31:0] asmr_load(input logic [5:0] addr, input asmr_pkg::asmr_shadow_t sh);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (addr)
			`ASMR_ADDR_STATUS:  v = {sh.status, 24'h000000};
			`ASMR_ADDR_CONTROL: v = {sh.control, 16'h0000};
			`ASMR_ADDR_IFACE:   v = {sh.iface, 16'h0000};
			`ASMR_ADDR_DATA:    v = {sh.data, sh.iface[`ASMR_IF_APPEND] ? sh.status : 8'h00};
			default:            v = 32'h00000000;
		endcase
		return v;
	endfunction : asmr_load

	// Register state, mclk domain
	logic                   rdy_reg;
	logic                   err_reg;
	logic                   crc_err_reg;
	logic [1:0]             chan_reg;
	logic [23:0]            data_reg;
	logic [15:0]            control_reg;
	logic [15:0]            iface_reg;
	logic                   wr_prev_reg;
	logic                   rd_prev_reg;
	logic                   filter_reset_reg;
	logic                   conv_start_reg;
	asmr_pkg::asmr_shadow_t shadow_reg;

	// Link state, sclk domain
	asmr_pkg::asmr_link_st_t st_reg;
	logic [5:0]              cnt_reg;
	logic [6:0]              cmd_reg;
	logic [7:0]              crc_reg;
	logic [5:0]              len_reg;
	logic                    is_read_reg;
	logic                    reading_reg;
	logic                    wr_flag_reg;
	logic                    rd_flag_reg;
	logic [5:0]              addr_reg;
	logic [23:0]             wdata_reg;
	logic                    crc_ok_reg;
	logic [31:0]             out_reg;

	// Crossings into mclk
	localparam logic [3:0] SYNC_RST = 4'h9;
	wire  [3:0] sync_in = {sync_n, rd_flag_reg, wr_flag_reg, cs_n};
	logic [3:0] sync_q;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			asmr_sync #(
				.RST_VAL (SYNC_RST[gi])
			) u_sync (
				.mclk (mclk),
				.nrst (nrst),
				.d    (sync_in[gi]),
				.q    (sync_q[gi])
			);
		end
	endgenerate

	wire cs_q   = sync_q[0];
	wire wr_q   = sync_q[1];
	wire rd_q   = sync_q[2];
	wire sync_q_n = sync_q[3];

	// Event decode, mclk
	wire       wr_seen     = wr_q & ~wr_prev_reg;
	wire       rd_seen     = rd_q & ~rd_prev_reg;
	wire       wr_ok       = wr_seen & crc_ok_reg;
	wire       wr_bad      = wr_seen & ~crc_ok_reg;
	wire       ctrl_wr     = wr_ok & (addr_reg == `ASMR_ADDR_CONTROL);
	wire       if_wr       = wr_ok & (addr_reg == `ASMR_ADDR_IFACE);
	wire       rd_data     = rd_seen & (addr_reg == `ASMR_ADDR_DATA);
	wire       rd_status   = rd_seen & (addr_reg == `ASMR_ADDR_STATUS);
	wire       sync_active = ~sync_q_n;
	wire [2:0] cur_mode    = control_reg[`ASMR_CT_MODE_LSB +: 3];
	wire       result_take = result.valid & (cur_mode != `ASMR_MODE_STANDBY) & ~ctrl_wr;
	wire       single_done = result_take & (cur_mode == `ASMR_MODE_SINGLE);

	wire [23:0] clamp_value = result.over  ? `ASMR_FULL_SCALE :
	                          result.under ? `ASMR_ZERO_SCALE : result.value;

	wire [7:0] status_word = {rdy_reg, err_reg, crc_err_reg, 3'h0, chan_reg};

	// Next values
	wire rdy_next = ctrl_wr ? 1'b1 :
	                (result_take | cal_done) ? 1'b0 :
	                rd_data ? 1'b1 : rdy_reg;

	wire err_next = result_take ? (result.over | result.under) :
	                (ctrl_wr | sync_active) ? 1'b0 : err_reg;

	wire crc_err_next = wr_bad ? 1'b1 : rd_status ? 1'b0 : crc_err_reg;

	wire [23:0] data_next = result_take ? clamp_value : data_reg;
	wire [1:0]  chan_next = result_take ? result.channel : chan_reg;

	wire [15:0] ctrl_standby = {control_reg[15:7], `ASMR_MODE_STANDBY, control_reg[3:0]};
	wire [15:0] control_next = ctrl_wr ? (wdata_reg[15:0] & `ASMR_CT_MASK) :
	                           single_done ? ctrl_standby : control_reg;
	wire [15:0] iface_next   = if_wr ? (wdata_reg[15:0] & `ASMR_IF_MASK) : iface_reg;

	wire asmr_pkg::asmr_shadow_t shadow_next = cs_q ?
		{status_word, control_reg, iface_reg, data_reg} : shadow_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdy_reg          <= 1'((`ASMR_STATUS_RST) >> `ASMR_ST_RDY);
			err_reg          <= 1'b0;
			crc_err_reg      <= 1'b0;
			chan_reg         <= 2'h0;
			data_reg         <= `ASMR_DATA_RST;
			control_reg      <= `ASMR_CONTROL_RST;
			iface_reg        <= `ASMR_IFACE_RST;
			wr_prev_reg      <= 1'b0;
			rd_prev_reg      <= 1'b0;
			filter_reset_reg <= 1'b0;
			conv_start_reg   <= 1'b0;
			shadow_reg       <= {`ASMR_STATUS_RST, `ASMR_CONTROL_RST, `ASMR_IFACE_RST, `ASMR_DATA_RST};
		end else begin
			rdy_reg          <= rdy_next;
			err_reg          <= err_next;
			crc_err_reg      <= crc_err_next;
			chan_reg         <= chan_next;
			data_reg         <= data_next;
			control_reg      <= control_next;
			iface_reg        <= iface_next;
			wr_prev_reg      <= wr_q;
			rd_prev_reg      <= rd_q;
			filter_reset_reg <= ctrl_wr;
			conv_start_reg   <= ctrl_wr;
			shadow_reg       <= shadow_next;
		end
	end

	assign filter_reset         = filter_reset_reg;
	assign conv_start           = conv_start_reg;
	assign reference_output_pin = control_reg[`ASMR_CT_REFEN];
	assign ctrl                 = {control_reg[`ASMR_CT_REFEN],
	                               control_reg[`ASMR_CT_DELAY_LSB +: 3],
	                               control_reg[`ASMR_CT_MODE_LSB +: 3],
	                               control_reg[`ASMR_CT_CLK_LSB +: 2]};

	// Serial engine, sclk domain
	// Shadow is frozen while chip select is low, so it is static here
	wire       crc_on    = shadow_reg.iface[`ASMR_IF_CRCEN];
	wire       append    = shadow_reg.iface[`ASMR_IF_APPEND];
	wire [7:0] cmd_byte  = {cmd_reg, din};
	wire       in_cmd    = (st_reg == asmr_pkg::ASMR_LK_CMD);
	wire       in_data   = (st_reg == asmr_pkg::ASMR_LK_DATA);
	wire       in_chk    = (st_reg == asmr_pkg::ASMR_LK_CHK);
	wire       cmd_done  = in_cmd & (cnt_reg == `ASMR_CMD_LAST);
	wire       cmd_ok    = cmd_done & ~cmd_byte[7];
	wire       data_last = in_data & (cnt_reg == (len_reg - 6'h01));
	wire       chk_last  = in_chk & (cnt_reg == `ASMR_CRC_LAST);
	wire       wr_bits   = in_data & ~is_read_reg;
	wire       crc_feed  = in_cmd | wr_bits | in_chk;
	wire [5:0] cmd_len   = asmr_len(cmd_byte[5:0], append);
	logic [7:0] crc_step;

	asmr_crc8 u_crc (
		.crc      (crc_reg),
		.bit_in   (din),
		.crc_next (crc_step)
	);

	asmr_pkg::asmr_link_st_t st_next;
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			asmr_pkg::ASMR_LK_CMD: begin
				if (cmd_done) begin
					st_next = cmd_byte[7] ? asmr_pkg::ASMR_LK_FIN : asmr_pkg::ASMR_LK_DATA;
				end
			end
			asmr_pkg::ASMR_LK_DATA: begin
				if (data_last) begin
					st_next = (!is_read_reg && crc_on) ? asmr_pkg::ASMR_LK_CHK : asmr_pkg::ASMR_LK_FIN;
				end
			end
			asmr_pkg::ASMR_LK_CHK: begin
				if (chk_last) begin
					st_next = asmr_pkg::ASMR_LK_FIN;
				end
			end
			asmr_pkg::ASMR_LK_FIN: st_next = asmr_pkg::ASMR_LK_FIN;
		endcase
	end

	wire       step_end     = cmd_done | data_last | chk_last;
	wire [5:0] cnt_next     = step_end ? 6'h00 :
	                          (st_reg == asmr_pkg::ASMR_LK_FIN) ? cnt_reg : cnt_reg + 6'h01;
	wire       reading_next = cmd_ok ? cmd_byte[6] : data_last ? 1'b0 : reading_reg;
	wire       rd_flag_next = rd_flag_reg | (cmd_ok & cmd_byte[6]);
	wire       wr_flag_next = wr_flag_reg | (data_last & ~is_read_reg & ~crc_on) | chk_last;

	// Frame control, cleared whenever chip select is high
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			st_reg      <= asmr_pkg::ASMR_LK_CMD;
			cnt_reg     <= 6'h00;
			cmd_reg     <= 7'h00;
			crc_reg     <= 8'h00;
			len_reg     <= `ASMR_LEN_BYTE;
			is_read_reg <= 1'b0;
			reading_reg <= 1'b0;
			wr_flag_reg <= 1'b0;
			rd_flag_reg <= 1'b0;
		end else begin
			st_reg      <= st_next;
			cnt_reg     <= cnt_next;
			cmd_reg     <= in_cmd ? cmd_byte[6:0] : cmd_reg;
			crc_reg     <= crc_feed ? crc_step : crc_reg;
			len_reg     <= cmd_done ? cmd_len : len_reg;
			is_read_reg <= cmd_done ? cmd_byte[6] : is_read_reg;
			reading_reg <= reading_next;
			wr_flag_reg <= wr_flag_next;
			rd_flag_reg <= rd_flag_next;
		end
	end

	// Frame payload, held past the frame for the mclk side
	always_ff @(posedge sclk) begin
		addr_reg   <= cmd_done ? cmd_byte[5:0] : addr_reg;
		wdata_reg  <= wr_bits ? {wdata_reg[22:0], din} : wdata_reg;
		crc_ok_reg <= (data_last & ~is_read_reg & ~crc_on) ? 1'b1 :
		              chk_last ? (crc_step == 8'h00) : crc_ok_reg;
		out_reg    <= (cmd_ok & cmd_byte[6]) ? asmr_load(cmd_byte[5:0], shadow_reg) :
		              (in_data & is_read_reg) ? {out_reg[30:0], 1'b0} : out_reg;
	end

	assign dout    = reading_reg ? out_reg[31] : rdy_reg;
	assign dout_oe = ~cs_n;

	// Checks
	sequence s_ctrl_write;
		ctrl_wr ##1 (filter_reset && conv_start && rdy_reg);
	endsequence

	property p_status_ro;
		@(posedge mclk) disable iff (!nrst)
		wr_ok && addr_reg == `ASMR_ADDR_STATUS && !result_take && !cal_done && !sync_active
		|=> $stable(status_word) && $stable(control_reg) && $stable(data_reg);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write changed state");

	property p_append_len;
		@(posedge sclk) disable iff (cs_n)
		cmd_ok && cmd_byte[6] && cmd_byte[5:0] == `ASMR_ADDR_DATA && append |=> len_reg == 6'h20;
	endproperty
	a_append_len: assert property (p_append_len) else $error("append read not 32 bits");

	property p_rdy_out;
		@(posedge mclk) disable iff (!nrst)
		!cs_n && !reading_reg && $stable(rdy_reg) |-> dout == rdy_reg && dout_oe;
	endproperty
	a_rdy_out: assert property (p_rdy_out) else $error("ready not on serial output");

	property p_new_result;
		@(posedge mclk) disable iff (!nrst)
		(result_take || (cal_done && !ctrl_wr)) |=> !rdy_reg;
	endproperty
	a_new_result: assert property (p_new_result) else $error("ready not low after result");

	property p_data_read;
		@(posedge mclk) disable iff (!nrst)
		rd_data && !result_take && !cal_done |=> rdy_reg;
	endproperty
	a_data_read: assert property (p_data_read) else $error("ready not restored by read");

	property p_clamp;
		@(posedge mclk) disable iff (!nrst)
		result_take && (result.over || result.under) |=>
		err_reg && (data_reg == ($past(result.over) ? 24'hffffff : 24'h000000));
	endproperty
	a_clamp: assert property (p_clamp) else $error("range clamp wrong");

	property p_err_hold;
		@(posedge mclk) disable iff (!nrst)
		!result_take && !ctrl_wr && !sync_active |=> $stable(err_reg);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("range flag moved without cause");

	property p_err_clear;
		@(posedge mclk) disable iff (!nrst)
		(ctrl_wr || sync_active) && !result_take |=> !err_reg;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("range flag not cleared");

	property p_crc_flag;
		@(posedge mclk) disable iff (!nrst)
		(wr_bad |=> crc_err_reg) and (rd_status && !wr_bad |=> !crc_err_reg);
	endproperty
	a_crc_flag: assert property (p_crc_flag) else $error("checksum flag wrong");

	property p_channel;
		@(posedge mclk) disable iff (!nrst)
		result_take ##1 !result_take[*2] |-> chan_reg == $past(result.channel, 2);
	endproperty
	a_channel: assert property (p_channel) else $error("channel tag wrong");

	property p_ctrl_write;
		@(posedge mclk) disable iff (!nrst)
		ctrl_wr |-> s_ctrl_write ##1 (!filter_reset && !conv_start);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write effects wrong");

	property p_reference;
		@(posedge mclk) disable iff (!nrst)
		ctrl_wr |=> reference_output_pin == $past(wdata_reg[15]) && control_reg[14:11] == 4'h0;
	endproperty
	a_reference: assert property (p_reference) else $error("reference enable wrong");

	property p_single;
		@(posedge mclk) disable iff (!nrst)
		single_done |=> ctrl.mode == `ASMR_MODE_STANDBY ##1 (ctrl.mode == `ASMR_MODE_STANDBY || $past(ctrl_wr));
	endproperty
	a_single: assert property (p_single) else $error("single mode did not stop");

	property p_reserved;
		@(posedge mclk) disable iff (!nrst)
		(control_reg & ~`ASMR_CT_MASK) == 16'h0000 && (iface_reg & ~`ASMR_IF_MASK) == 16'h0000
		&& status_word[4:2] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule : asmr_core

`default_nettype wire

// >>> test/asmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module asmr_host_model (
	// Serial link
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	// One command per frame, MSB first; clock idles high between frames
	task frame(input logic [7:0] cmd, input logic [31:0] wd, input int n, output logic [31:0] rd,
		output logic rb);
		logic [39:0] sh;
		sh = {cmd, wd << (32 - n)};
		rd = 32'h0;
		#3 cs_n = 1'b0;
		#40;
		rb = dout & dout_oe;
		for (int i = 0; i < 8 + n; i++) begin
			sclk = 1'b0;
			din  = sh[39 - i];
			#40;
			// Read bits taken as they come, no checksum on reads
			if (i >= 8)
				rd = {rd[30:0], dout};
			sclk = 1'b1;
			#40;
		end
		cs_n = 1'b1;
		din  = ~din;
		#80;
	endtask : frame
endmodule : asmr_host_model
`default_nettype wire

// >>> test/adc_status_mode_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "asmr_defs.svh"

module adc_status_mode_regs_tb_top;
	logic                   mclk;
	logic                   nrst;
	wire logic              sclk;
	wire logic              cs_n;
	wire logic              din;
	logic                   dout;
	logic                   dout_oe;
	logic                   sync_n;
	asmr_pkg::asmr_result_t res;
	logic                   cal_done;
	asmr_pkg::asmr_ctrl_t   ctrl;
	logic                   filter_reset;
	logic                   conv_start;
	logic                   ref_pin;
	int                     err_total;
	int                     tests_run;
	int                     seed;
	int                     fr_cnt;
	int                     cv_cnt;
	int                     f0;
	logic [31:0]            rv;
	logic [23:0]            v;
	logic [1:0]             ch;
	logic                   ov;
	logic                   un;
	logic                   rb;

	asmr_core asmr_core_i (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .sync_n(sync_n), .result(res), .cal_done(cal_done), .ctrl(ctrl),
		.filter_reset(filter_reset), .conv_start(conv_start), .reference_output_pin(ref_pin));

	asmr_host_model asmr_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			fr_cnt <= 0;
			cv_cnt <= 0;
		end else begin
			if (filter_reset === 1'b1)
				fr_cnt <= fr_cnt + 1;
			if (conv_start === 1'b1)
				cv_cnt <= cv_cnt + 1;
		end
	end

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t read %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task chk_port(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t port %h expected %h", $time, got, exp);
		end
	endtask : chk_port

	task rd(input logic [5:0] a, input int n);
		asmr_host_model_i.frame({2'b01, a}, 32'h0, n, rv, rb);
	endtask : rd

	task wr(input logic [5:0] a, input logic [31:0] d, input int n);
		logic [31:0] unused_rd;
		logic        unused_rb;
		asmr_host_model_i.frame({2'b00, a}, d, n, unused_rd, unused_rb);
	endtask : wr

	task push(input logic [23:0] pv, input logic [1:0] pc, input logic po, input logic pu);
		@(posedge mclk);
		res <= {1'b1, pv, pc, po, pu};
		@(posedge mclk);
		res.valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : push

	function automatic logic [23:0] clamp(input logic [23:0] x, input logic o, input logic u);
		return o ? `ASMR_FULL_SCALE : (u ? `ASMR_ZERO_SCALE : x);
	endfunction : clamp

	function automatic logic [7:0] crc8(input logic [23:0] b);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? `ASMR_CRC_POLY : 8'h00);
		return c;
	endfunction : crc8

	task test_done;
		$display("Comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	initial begin
		#500000;
		err_total++;
		test_done;
	end

	initial begin
		seed = 21;
		err_total = 0;
		tests_run = 0;
		nrst = 1'b0;
		sync_n = 1'b1;
		cal_done = 1'b0;
		res = '0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv, 32'h80);
		chk_port(rb, 1'b1);
		rd(`ASMR_ADDR_CONTROL, 16);
		chk_reg(rv, 32'h0);
		chk_port({ref_pin, ctrl[7:0]}, 9'h0);
		$display("Test reset done");
		wr(`ASMR_ADDR_IFACE, 32'h0040, 16);
		for (int k = 0; k < 8; k++) begin
			rv = $random(seed);
			v = rv[23:0];
			ch = k[1:0];
			ov = (k == 0) || (k > 1 && rv[27:26] == 2'h0);
			un = (k == 1) || (k > 1 && rv[27:26] == 2'h1);
			push(v, ch, ov, un);
			rd(`ASMR_ADDR_DATA, 32);
			chk_reg(rv, {clamp(v, ov, un), 1'b0, ov | un, 4'h0, ch});
			chk_port(rb, 1'b0);
			rd(`ASMR_ADDR_STATUS, 8);
			chk_reg(rv, {24'h0, 1'b1, ov | un, 4'h0, ch});
		end
		$display("Test results done");
		push(24'h0, 2'h0, 1'b1, 1'b0);
		@(posedge mclk) sync_n <= 1'b0;
		repeat (6) @(posedge mclk);
		sync_n <= 1'b1;
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv, 32'h00);
		push(24'h0, 2'h0, 1'b1, 1'b0);
		f0 = fr_cnt;
		wr(`ASMR_ADDR_CONTROL, 32'hf817, 16);
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv, 32'h80);
		chk_reg(fr_cnt - f0, 32'h1);
		chk_reg(fr_cnt - cv_cnt, 32'h0);
		rd(`ASMR_ADDR_CONTROL, 16);
		chk_reg(rv, 32'h8014);
		chk_port(ctrl, {1'b1, 3'h0, `ASMR_MODE_SINGLE, 2'h1});
		chk_port({8'h00, ref_pin}, 9'h001);
		$display("Test control done");
		push(24'habcdef, 2'h2, 1'b0, 1'b0);
		chk_port(ctrl.mode, `ASMR_MODE_STANDBY);
		push(24'h111111, 2'h3, 1'b0, 1'b0);
		rd(`ASMR_ADDR_DATA, 32);
		chk_reg(rv, 32'habcdef02);
		wr(`ASMR_ADDR_CONTROL, 32'h8004, 16);
		push(24'h222222, 2'h1, 1'b0, 1'b0);
		push(24'h333333, 2'h3, 1'b0, 1'b0);
		rd(`ASMR_ADDR_DATA, 32);
		chk_reg(rv, 32'h33333303);
		wr(`ASMR_ADDR_STATUS, 32'hff, 8);
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv, 32'h83);
		@(posedge mclk) cal_done <= 1'b1;
		@(posedge mclk) cal_done <= 1'b0;
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv, 32'h03);
		$display("Test modes done");
		wr(`ASMR_ADDR_IFACE, 32'h0044, 16);
		wr(`ASMR_ADDR_CONTROL, {8'h0, 16'h0, crc8({8'h01, 16'h0}) ^ 8'h01}, 24);
		rd(`ASMR_ADDR_CONTROL, 16);
		chk_reg(rv, 32'h8004);
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv & 32'h20, 32'h20);
		rd(`ASMR_ADDR_STATUS, 8);
		chk_reg(rv & 32'h20, 32'h00);
		wr(`ASMR_ADDR_CONTROL, {8'h0, 16'h8024, crc8({8'h01, 16'h8024})}, 24);
		rd(`ASMR_ADDR_CONTROL, 16);
		chk_reg(rv, 32'h8024);
		$display("Test checksum done");
		test_done;
	end
endmodule : adc_status_mode_regs_tb_top
`default_nettype wire
